// [hdl/art_pwm_timer.sv]
// Auto-reload 8-bit PWM timer with capture, APB register slave
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "art_pwm_defs.svh"

// Function
// - Prescaler input is pclk when source select is 0, external count pin when 1.
// - Counter rate is prescaler input divided by two to the divider code.
// - Counter run bit low freezes prescaler and counter.
// - Force reload reads zero; writing one loads reload value, clears prescaler.
// - Wrap interrupt request follows wrap flag AND its enable, registered one clock later.
// - Wrap flag sets on FFh wrap, clears when status register is read.
// - Counter access register reads live count and overwrites it while running.
// - On wrap counter reloads and PWM levels switch per polarity.
// - Output enable bit connects each PWM channel to its pin.
// - Polarity 0: high while count <= compare, low above; 1 inverts.
// - Changing polarity inverts the output at once.
// - Duty sets second edge; reload value sets the common first edge.
// - Top two capture status bits read as zero.
// - Capture edge bit: 0 falling, 1 rising edge triggers capture.
// - Each capture channel has its own interrupt enable.
// - Capture flag sets on capture, clears on reading that capture data.
// - All control registers reset to zero.
// - Compare shadow loads from duty register only at wrap.
// - Selected capture edge copies current count into capture data.
// - Further captures blocked until capture data is read.
// - Counter access write also clears the prescaler.
module art_pwm_timer import art_pwm_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int NUM_PWM = 4,
  parameter int NUM_CAP = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_clk,
  input wire logic [NUM_CAP-1:0] capture_pin,
  output logic [NUM_PWM-1:0] pwm_out,
  output logic [NUM_PWM-1:0] pwm_oe,
  output logic wrap_irq,
  output logic [NUM_CAP-1:0] capture_irq
);

  if (NUM_PWM != 4 || NUM_CAP != 2 || ADDR_W < 6) begin : g_check
    $error("art_pwm_timer: unsupported channel count or address width");
  end

  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    logic [7:0] off;
    off = 8'(a);
    if (a[ADDR_W-1:0] != ADDR_W'(off)) return SEL_NONE;
    if (off == `OFF_TIMER_CONTROL_STATUS) return SEL_CSR;
    if (off == `OFF_LIVE_COUNTER_ACCESS) return SEL_CAR;
    if (off == `OFF_RELOAD_VALUE) return SEL_ARR;
    if (off == `OFF_PWM_OUTPUT_CONTROL) return SEL_PWM;
    if (off >= `OFF_CHANNEL_DUTY0 && off <= `OFF_CHANNEL_DUTY3 && off[1:0] == 2'b00)
      return SEL_DUTY;
    if (off == `OFF_CAPTURE_CONTROL_STATUS) return SEL_CAP;
    if (off == `OFF_CAPTURE_DATA1 || off == `OFF_CAPTURE_DATA2) return SEL_ICR;
    return SEL_NONE;
  endfunction

  // Low bits of the prescaler that must be all ones for a counter tick
  function automatic logic [6:0] tap_mask(input logic [2:0] code);
    return 7'((8'h01 << code) - 8'h01);
  endfunction

  timer_ctl_t ctl_r;
  pwm_ctl_t pwm_ctl_r;
  cap_ctl_t cap_ctl_r;
  logic wrap_flag_r;
  logic [7:0] cnt_r;
  logic [6:0] pre_r;
  logic [7:0] reload_r;
  logic [7:0] duty_r [NUM_PWM];
  logic [NUM_CAP-1:0] cap_flag;
  logic [7:0] cap_data [NUM_CAP];
  logic [NUM_CAP-1:0] cap_clr_now;
  logic [7:0] shadow0;

  // APB phases
  logic setup;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  reg_sel_t sel;
  logic [1:0] duty_idx;
  logic icr_idx;
  logic [7:0] wbyte;

  assign setup = psel && !penable;
  assign acc = psel && penable && pready;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;
  assign sel = decode(paddr);
  assign duty_idx = paddr[3:2];
  assign icr_idx = paddr[2];
  assign wbyte = pwdata[7:0];

  // Read clears only the flags that the read actually reported
  logic wrap_clr_r;
  logic [NUM_CAP-1:0] cap_clr_r;
  logic [7:0] rd_val;

  always_comb begin
    rd_val = `RST_BYTE;
    unique case (sel)
      SEL_CSR: rd_val = {ctl_r.clock_source_select, ctl_r.divider_code, ctl_r.counter_run,
                         1'b0, ctl_r.wrap_irq_enable, wrap_flag_r};
      SEL_CAR: rd_val = cnt_r;
      SEL_ARR: rd_val = reload_r;
      SEL_PWM: rd_val = pwm_ctl_r;
      SEL_DUTY: rd_val = duty_r[duty_idx];
      SEL_CAP: rd_val = {2'b00, cap_ctl_r, cap_flag};
      SEL_ICR: rd_val = cap_data[icr_idx];
      SEL_NONE: rd_val = `RST_BYTE;
    endcase
  end

  // Zero-wait slave: answer in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && (sel == SEL_NONE);
      if (setup && !pwrite) begin
        prdata <= {24'h00_0000, rd_val};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_clr_r <= 1'b0;
      cap_clr_r <= '0;
    end else if (setup) begin
      wrap_clr_r <= !pwrite && sel == SEL_CSR && wrap_flag_r;
      cap_clr_r <= '0;
      if (!pwrite && sel == SEL_ICR) begin
        cap_clr_r[icr_idx] <= cap_flag[icr_idx];
      end
    end
  end

  assign cap_clr_now = rd_acc ? cap_clr_r : '0;

  // Software-written control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r <= '0;
      pwm_ctl_r <= '0;
      cap_ctl_r <= '0;
      reload_r <= `RST_BYTE;
    end else if (wr_acc) begin
      unique case (sel)
        SEL_CSR: ctl_r <= '{clock_source_select: wbyte[`CSR_CLOCK_SOURCE_SELECT],
                           divider_code: wbyte[`CSR_DIVIDER_CODE_HI:`CSR_DIVIDER_CODE_LO],
                           counter_run: wbyte[`CSR_COUNTER_RUN],
                           wrap_irq_enable: wbyte[`CSR_WRAP_IRQ_ENABLE]};
        SEL_ARR: reload_r <= wbyte;
        SEL_PWM: pwm_ctl_r <= wbyte;
        SEL_CAP: cap_ctl_r <= wbyte[5:2];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PWM; i++) begin
        duty_r[i] <= `RST_BYTE;
      end
    end else if (wr_acc && sel == SEL_DUTY) begin
      duty_r[duty_idx] <= wbyte;
    end
  end

  // External count pin: two-flop synchroniser plus edge stage
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
    end else begin
      ext_s1_r <= ext_count_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  assign ext_rise = ext_s2_r && !ext_s3_r;

  // Prescaler and counter
  logic pre_tick;
  logic cnt_tick;
  logic wrap;
  logic car_wr;
  logic force_wr;
  logic [6:0] mask;

  assign mask = tap_mask(ctl_r.divider_code);
  assign pre_tick = ctl_r.counter_run &&
                    (ctl_r.clock_source_select ? ext_rise : 1'b1);
  assign cnt_tick = pre_tick && ((pre_r & mask) == mask);
  assign wrap = cnt_tick && cnt_r == `COUNTER_TOP;
  assign car_wr = wr_acc && sel == SEL_CAR;
  assign force_wr = wr_acc && sel == SEL_CSR && wbyte[`CSR_FORCE_RELOAD];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= `RST_PRESCALER;
    end else if (car_wr || force_wr) begin
      pre_r <= `RST_PRESCALER;
    end else if (pre_tick) begin
      pre_r <= pre_r + 7'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= `RST_BYTE;
    end else if (car_wr) begin
      cnt_r <= wbyte;
    end else if (force_wr) begin
      cnt_r <= reload_r;
    end else if (wrap) begin
      cnt_r <= reload_r;
    end else if (cnt_tick) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_r <= 1'b0;
    end else if (wrap) begin
      wrap_flag_r <= 1'b1;
    end else if (rd_acc && wrap_clr_r) begin
      wrap_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_irq <= 1'b0;
    end else begin
      wrap_irq <= wrap_flag_r && ctl_r.wrap_irq_enable;
    end
  end

  // PWM channels
  for (genvar g = 0; g < NUM_PWM; g++) begin : g_pwm
    logic [7:0] shadow_r;
    logic out_r;
    logic oe_r;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shadow_r <= `RST_BYTE;
      end else if (wrap) begin
        shadow_r <= duty_r[g];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_r <= 1'b0;
        oe_r <= 1'b0;
      end else begin
        oe_r <= pwm_ctl_r.pwm_oe[g];
        out_r <= pwm_ctl_r.pwm_oe[g] &&
                 ((cnt_r <= shadow_r) ^ pwm_ctl_r.pwm_polarity[g]);
      end
    end

    assign pwm_out[g] = out_r;
    assign pwm_oe[g] = oe_r;
  end

  assign shadow0 = g_pwm[0].shadow_r;

  // Capture channels
  for (genvar c = 0; c < NUM_CAP; c++) begin : g_cap
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic hit;
    logic flag_r;
    logic [7:0] data_r;
    logic irq_r;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end else begin
        s1_r <= capture_pin[c];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    assign hit = cap_ctl_r.capture_edge[c] ? (s2_r && !s3_r) : (!s2_r && s3_r);

    // A capture in the clearing cycle is kept
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        flag_r <= 1'b0;
        data_r <= `RST_BYTE;
      end else if (hit && (!flag_r || cap_clr_now[c])) begin
        flag_r <= 1'b1;
        data_r <= cnt_r;
      end else if (cap_clr_now[c]) begin
        flag_r <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_r <= 1'b0;
      end else begin
        irq_r <= flag_r && cap_ctl_r.capture_irq_enable[c];
      end
    end

    assign cap_flag[c] = flag_r;
    assign cap_data[c] = data_r;
    assign capture_irq[c] = irq_r;
  end

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_run_freeze;
    (!ctl_r.counter_run && !wr_acc) |=> ($stable(cnt_r) && $stable(pre_r));
  endproperty
  a_run_freeze: assert property (p_run_freeze) else $error("count moved while stopped");

  property p_wrap_reload;
    (wrap && !wr_acc) |=> (cnt_r == $past(reload_r) && wrap_flag_r);
  endproperty
  a_wrap_reload: assert property (p_wrap_reload) else $error("no reload on wrap");

  // No setup now means no access in the next cycle either
  property p_flag_hold;
    (wrap_flag_r && !rd_acc && !setup) |=> wrap_flag_r [*2];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("wrap flag lost");

  property p_irq_gate;
    wrap_irq |-> $past(wrap_flag_r && ctl_r.wrap_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("wrap irq without cause");

  property p_force;
    force_wr |=> (cnt_r == $past(reload_r) && pre_r == `RST_PRESCALER);
  endproperty
  a_force: assert property (p_force) else $error("force reload failed");

  property p_car_write;
    car_wr |=> (cnt_r == $past(wbyte) && pre_r == `RST_PRESCALER);
  endproperty
  a_car_write: assert property (p_car_write) else $error("counter write failed");

  property p_shadow;
    !wrap |=> $stable(shadow0);
  endproperty
  a_shadow: assert property (p_shadow) else $error("compare changed off wrap");

  property p_polarity;
    ($changed(pwm_ctl_r.pwm_polarity[0]) && $stable(cnt_r) && $stable(shadow0) &&
     pwm_ctl_r.pwm_oe[0] && $past(pwm_ctl_r.pwm_oe[0])) |=> pwm_out[0] != $past(pwm_out[0]);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity not applied");

  property p_cap_block;
    (cap_flag[0] && !cap_clr_now[0]) |=> $stable(cap_data[0]);
  endproperty
  a_cap_block: assert property (p_cap_block) else $error("capture overwrote data");

  property p_resv;
    $past(setup && !pwrite && sel == SEL_CAP) |-> prdata[7:6] == 2'b00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");

endmodule

// [hdl/art_pwm_defs.svh]
// Register offsets, field positions and reset values of the auto-reload PWM timer
`ifndef ART_PWM_DEFS_SVH
`define ART_PWM_DEFS_SVH

// Byte offsets of the register words
`define OFF_TIMER_CONTROL_STATUS 8'h00
`define OFF_LIVE_COUNTER_ACCESS 8'h04
`define OFF_RELOAD_VALUE 8'h08
`define OFF_PWM_OUTPUT_CONTROL 8'h0C
`define OFF_CHANNEL_DUTY0 8'h10
`define OFF_CHANNEL_DUTY3 8'h1C
`define OFF_CAPTURE_CONTROL_STATUS 8'h20
`define OFF_CAPTURE_DATA1 8'h28
`define OFF_CAPTURE_DATA2 8'h2C

// timer_control_status fields
`define CSR_CLOCK_SOURCE_SELECT 7
`define CSR_DIVIDER_CODE_HI 6
`define CSR_DIVIDER_CODE_LO 4
`define CSR_COUNTER_RUN 3
`define CSR_FORCE_RELOAD 2
`define CSR_WRAP_IRQ_ENABLE 1
`define CSR_WRAP_FLAG 0

// pwm_output_control fields
`define PWM_OE_HI 7
`define PWM_OE_LO 4
`define PWM_POL_HI 3
`define PWM_POL_LO 0

// capture_control_status fields
`define CAP_EDGE_LO 4
`define CAP_IRQ_ENABLE_LO 2
`define CAP_FLAG_LO 0

// Reset values and counter top
`define RST_BYTE 8'h00
`define RST_PRESCALER 7'h00
`define COUNTER_TOP 8'hFF

`endif

// [hdl/art_pwm_pkg.sv]
// Types shared by the auto-reload PWM timer
package art_pwm_pkg;

  typedef struct packed {
    logic clock_source_select;
    logic [2:0] divider_code;
    logic counter_run;
    logic wrap_irq_enable;
  } timer_ctl_t;

  typedef struct packed {
    logic [3:0] pwm_oe;
    logic [3:0] pwm_polarity;
  } pwm_ctl_t;

  typedef struct packed {
    logic [1:0] capture_edge;
    logic [1:0] capture_irq_enable;
  } cap_ctl_t;

  typedef enum logic [2:0] {
    SEL_CSR, SEL_CAR, SEL_ARR, SEL_PWM, SEL_DUTY, SEL_CAP, SEL_ICR, SEL_NONE
  } reg_sel_t;

endpackage

// [dv/pwm_auto_reload_timer_regs_tb.sv]
// Self-checking bench for the auto-reload PWM timer register block
`timescale 1ns/1ns
module pwm_auto_reload_timer_regs_tb;
  typedef struct {logic [7:0] a; logic [7:0] wd; logic [7:0] ex;} row_t;
  localparam int LIMIT = 12000;
  logic pclk, presetn, psel, penable, pwrite, ext_count_clk;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, got;
  logic pready, pslverr, wrap_irq, err;
  logic [1:0] capture_pin, capture_irq;
  logic [3:0] pwm_out, pwm_oe;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int e;
  row_t rows[8];

  art_pwm_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_clk(ext_count_clk), .capture_pin(capture_pin),
    .pwm_out(pwm_out), .pwm_oe(pwm_oe), .wrap_irq(wrap_irq), .capture_irq(capture_irq));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      $display("timeout after %0d cycles", cyc);
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    n_checks++;
    if (sn !== ex) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, sn);
    end
  endtask

  // One APB transfer; answer taken at the rising edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    got = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h00_0000, ex}, got);
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      ext_count_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_count_clk <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    cyc_wait(6);
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge pclk);
    capture_pin[i] <= v;
    cyc_wait(6);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_count_clk = 1'b0;
    capture_pin = 2'b00;
    rows = '{'{8'h08, 8'hA5, 8'hA5}, '{8'h0C, 8'h5A, 8'h5A}, '{8'h10, 8'h11, 8'h11},
      '{8'h14, 8'h22, 8'h22}, '{8'h18, 8'h33, 8'h33}, '{8'h1C, 8'h44, 8'h44},
      '{8'h20, 8'hFF, 8'h3C}, '{8'h00, 8'h76, 8'h72}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].wd);
      rd($sformatf("reg %h", rows[i].a), rows[i].a, rows[i].ex);
    end
    rd("reloaded count", 8'h04, 8'hA5);
    apb(1'b0, 8'h24, 8'h00);
    chk("unmapped err", 32'h0000_0001, {31'h0000_0000, err});
    chk("unmapped data", 32'h0000_0000, got);
    cyc_wait(1);
    chk("ready stands one cycle", 32'h0000_0000, {31'h0000_0000, pready});
    wr(8'h04, 8'h40);
    cyc_wait(20);
    rd("frozen count", 8'h04, 8'h40);
    $display("test registers done");

    for (int k = 0; k < 8; k++) begin
      wr(8'h04, 8'h00);
      wr(8'h00, {1'b0, k[2:0], 4'h8});
      cyc_wait(128);
      wr(8'h00, 8'h00);
      apb(1'b0, 8'h04, 8'h00);
      e = 130 >> k;
      chk($sformatf("divider %0d", k), 1, (got + 32'h0000_0001 >= e) && (got <= e + 1));
    end
    $display("test divider done");

    wr(8'h08, 8'hF0);
    wr(8'h04, 8'hFA);
    wr(8'h00, 8'h0A);
    repeat (40) begin
      @(negedge pclk);
      if (wrap_irq === 1'b1)
        break;
    end
    chk("wrap irq", 1, {31'h0000_0000, wrap_irq});
    wr(8'h00, 8'h02);
    apb(1'b0, 8'h04, 8'h00);
    chk("count after wrap", 1, {31'h0000_0000, got[7:0] >= 8'hF0});
    rd("status flag", 8'h00, 8'h03);
    rd("status cleared", 8'h00, 8'h02);
    cyc_wait(2);
    chk("wrap irq low", 0, {31'h0000_0000, wrap_irq});
    $display("test wrap done");

    wr(8'h08, 8'h00);
    wr(8'h10, 8'h80);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h10);
    wr(8'h1C, 8'h80);
    wr(8'h0C, 8'hF8);
    wr(8'h00, 8'h88);
    wr(8'h04, 8'hFF);
    ext_pulses(1);
    chk("pwm at zero", 32'h0000_0007, {28'h000_0000, pwm_out});
    chk("no wrap irq", 0, {31'h0000_0000, wrap_irq});
    wr(8'h10, 8'h00);
    wr(8'h04, 8'h20);
    cyc_wait(3);
    chk("pwm mid", 32'h0000_0001, {28'h000_0000, pwm_out});
    wr(8'h0C, 8'hF9);
    cyc_wait(3);
    chk("pwm flipped", 32'h0000_0000, {28'h000_0000, pwm_out});
    wr(8'h0C, 8'hD9);
    cyc_wait(3);
    chk("pwm enables", 32'h0000_000D, {28'h000_0000, pwm_oe});
    ext_pulses(10);
    rd("ext status", 8'h00, 8'h89);
    wr(8'h00, 8'h00);
    rd("ext count", 8'h04, 8'h2A);
    $display("test pwm done");

    wr(8'h04, 8'h37);
    wr(8'h20, 8'h1C);
    pin(0, 1'b1);
    pin(1, 1'b1);
    chk("cap irq", 32'h0000_0001, {30'h0000_0000, capture_irq});
    rd("cap status", 8'h20, 8'h1D);
    pin(0, 1'b0);
    wr(8'h04, 8'h38);
    pin(0, 1'b1);
    rd("cap data1", 8'h28, 8'h37);
    rd("cap status clr", 8'h20, 8'h1C);
    pin(1, 1'b0);
    rd("cap data2", 8'h2C, 8'h38);
    wr(8'h20, 8'h00);
    pin(0, 1'b0);
    chk("cap irq masked", 0, {30'h0000_0000, capture_irq});
    rd("cap flag masked", 8'h20, 8'h01);
    $display("test capture done");

    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 48; a += 4)
      rd($sformatf("reset %h", a), a[7:0], 8'h00);
    chk("oe after reset", 0, {28'h000_0000, pwm_oe});
    $display("test reset done");
    conclude();
  end
endmodule
